/* File: logic/css_defines.svh */
/*
 Constants of the control-pin setting selector.
 Assumes inclusion by its bare name from the design and the bench.
*/
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

// Register byte addresses
`define CSS_ADDR_SET0      12'h000
`define CSS_ADDR_SETSTEP   12'h004
`define CSS_ADDR_PLLCFG    12'h020
`define CSS_ADDR_GENCFG    12'h024
`define CSS_ADDR_STATUS    12'h028
`define CSS_ADDR_RELOAD    12'h02C

// Setting word fields: [0] freq, [3:1] spread code, [4] out23, [5] out1
`define CSS_SET_FREQ_BIT   0
`define CSS_SET_SPR_LSB    1
`define CSS_SET_OUT23_BIT  4
`define CSS_SET_OUT1_BIT   5

// PLL config fields: [0] down spread, [2:1] stateA, [4:3] stateB
`define CSS_PLL_DOWN_BIT   0
`define CSS_PLL_STA_LSB    1
`define CSS_PLL_STB_LSB    3
// Generic config: [1:0] out1 stateA, [3:2] out1 stateB,
// [4] pins as control, [5] bypass, [10:6] load cap
`define CSS_GEN_Y1A_LSB    0
`define CSS_GEN_Y1B_LSB    2
`define CSS_GEN_PINCTL_BIT 4
`define CSS_GEN_BYP_BIT    5
`define CSS_GEN_CAP_LSB    6

// Nonvolatile factory defaults
`define CSS_DEF_SET0       6'h00
`define CSS_DEF_SET1       6'h30
`define CSS_DEF_SETX       6'h30
`define CSS_DEF_PLLCFG     5'h0C
`define CSS_DEF_GENCFG     11'h00C
`define CSS_CAP_MAX        5'h14

`endif

/* File: logic/css_pkg.sv */
/*
 Types of the control-pin setting selector.
 Assumes css_defines.svh is on the include path.
*/
package css_pkg;
	// Output state codes
	typedef enum logic [1:0] {
		CSS_OUT_PDOWN = 2'h0,
		CSS_OUT_HIZ   = 2'h1,
		CSS_OUT_LOW   = 2'h2,
		CSS_OUT_ACT   = 2'h3
	} css_out_t;

	typedef struct packed {
		logic       freqSelB;
		logic       spreadDown;
		logic [2:0] spreadCode;
		css_out_t   outState23;
		css_out_t   outState1;
		logic       pllBypass;
		logic       devicePowerDown;
		logic [4:0] loadCap;
	} css_apply_t;

	typedef enum logic [1:0] {
		CSS_WR_IDLE = 2'h1,
		CSS_WR_RESP = 2'h2
	} css_wr_t;
endpackage

/* File: logic/css_selector.sv */
/*
 Control-pin setting selector: picks one of eight settings from the
 select pins, registers its fields and drives the PLL, spread and
 output-state controls. Registers reached over AXI4-Lite.
 Assumes select pins are asynchronous; analog PLL and serial bus
 logic sit outside and reach the registers through the AXI port.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
// What this block does
// - Three select pins choose the control setting
// - Eight stored settings, pin combination picks one
// - Setting holds frequency, spread, output fields
// - Spread applies chosen type and amount
// - Frequency field picks one of two configs
// - Output state sets drive and power down
// - Three-bit spread code passed per PLL
// - Spread type is center or down
// - Spread type and output two/three states in PLL register
// - Settings may drive low, Hi-Z, power down, bypass
// - Load capacitance programmable zero to 20 pF
// - Reset loads factory defaults until reprogrammed
// - Host can write every setting
// - Each state: power down, Hi-Z, low, active
// - Bus-mode pins one and two read as zero
// - Default: pin zero toggles output one off/on, outputs two and three low/Hi-Z
`timescale 1ns/100ps
`default_nettype none
`include "css_defines.svh"

module css_selector (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	// Select pins
	input  wire logic             selectPinZero,
	input  wire logic             selectPinOne,
	input  wire logic             selectPinTwo,
	// AXI4-Lite slave
	input  wire logic [11:0]      s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output var  logic             s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output var  logic             s_axi_wready,
	output var  logic [1:0]       s_axi_bresp,
	output var  logic             s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [11:0]      s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output var  logic             s_axi_arready,
	output var  logic [31:0]      s_axi_rdata,
	output var  logic [1:0]       s_axi_rresp,
	output var  logic             s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// Applied controls
	output var  css_pkg::css_apply_t applied,
	output var  logic [2:0]       settingIndex
);
	import css_pkg::*;

	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [2:0]      syncA;
		logic [2:0]      syncB;
		logic [7:0][5:0] setWord;
		logic [4:0]      pllCfg;
		logic [10:0]     genCfg;
		logic [2:0]      index;
		css_apply_t      apply;
		logic            awHeld;
		logic [11:0]     awAddr;
		logic            wHeld;
		logic [31:0]     wData;
		logic [3:0]      wStrb;
		css_wr_t         wrState;
		logic            bValid;
		logic [1:0]      bResp;
		logic            rValid;
		logic [31:0]     rData;
		logic [1:0]      rResp;
	} css_state_t;

	css_state_t st;
	css_state_t next_st;
	logic [7:0][5:0] defaultSet;
	logic [2:0] pinIndex;
	logic [5:0] chosen;
	logic [31:0] wMerged;
	logic [31:0] rWord;
	logic rHit;

	////////////////////////////////////////////////////////////////////
	// Factory settings: only pin zero matters by default
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : gDef
			if (gi == 0) begin : gZero
				assign defaultSet[gi] = `CSS_DEF_SET0;
			end else if (gi == 1) begin : gOne
				assign defaultSet[gi] = `CSS_DEF_SET1;
			end else begin : gRest
				assign defaultSet[gi] = `CSS_DEF_SETX;
			end
		end
	endgenerate

	// Pins in bus mode are forced to zero so bus traffic cannot
	// flip the setting
	always_comb begin
		pinIndex[0] = st.syncB[0];
		pinIndex[1] = st.syncB[1] & st.genCfg[`CSS_GEN_PINCTL_BIT];
		pinIndex[2] = st.syncB[2] & st.genCfg[`CSS_GEN_PINCTL_BIT];
	end

	assign chosen = st.setWord[st.index];

	// Byte-lane merge onto the addressed register
	always_comb begin
		rWord = 32'h0000_0000;
		rHit = 1'b1;
		case (st.awAddr)
			`CSS_ADDR_PLLCFG: rWord = {27'h0, st.pllCfg};
			`CSS_ADDR_GENCFG: rWord = {21'h0, st.genCfg};
			default:
				if (st.awAddr < `CSS_ADDR_PLLCFG && st.awAddr[1:0] == 2'h0)
					rWord = {26'h0, st.setWord[st.awAddr[4:2]]};
				else
					rHit = 1'b0;
		endcase
		for (int b = 0; b < 4; b++) begin
			wMerged[b*8 +: 8] = st.wStrb[b] ? st.wData[b*8 +: 8]
				: rWord[b*8 +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		// Two-stage synchroniser; only stage B is read
		next_st.syncA = {selectPinTwo, selectPinOne, selectPinZero};
		next_st.syncB = st.syncA;
		next_st.index = pinIndex;
		// All fields change on one edge, never piecemeal
		next_st.apply.freqSelB = chosen[`CSS_SET_FREQ_BIT];
		next_st.apply.spreadCode =
			chosen[`CSS_SET_SPR_LSB +: 3];
		next_st.apply.spreadDown = st.pllCfg[`CSS_PLL_DOWN_BIT];
		next_st.apply.outState23 = css_out_t'(chosen[`CSS_SET_OUT23_BIT]
			? st.pllCfg[`CSS_PLL_STB_LSB +: 2]
			: st.pllCfg[`CSS_PLL_STA_LSB +: 2]);
		next_st.apply.outState1 = css_out_t'(chosen[`CSS_SET_OUT1_BIT]
			? st.genCfg[`CSS_GEN_Y1B_LSB +: 2]
			: st.genCfg[`CSS_GEN_Y1A_LSB +: 2]);
		next_st.apply.pllBypass = st.genCfg[`CSS_GEN_BYP_BIT];
		// Whole device down only when every output is powered down
		next_st.apply.devicePowerDown =
			(next_st.apply.outState1 == CSS_OUT_PDOWN) &&
			(next_st.apply.outState23 == CSS_OUT_PDOWN);
		next_st.apply.loadCap = st.genCfg[`CSS_GEN_CAP_LSB +: 5];

		// Write path: address and data accepted in either order
		if (s_axi_awvalid && !st.awHeld) begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.wHeld) begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end
		case (st.wrState)
			CSS_WR_IDLE:
				if (st.awHeld && st.wHeld) begin
					next_st.bResp = 2'h0;
					if (st.awAddr == `CSS_ADDR_PLLCFG) begin
						next_st.pllCfg = wMerged[4:0];
					end else if (st.awAddr == `CSS_ADDR_GENCFG) begin
						next_st.genCfg = wMerged[10:0];
						// Clamp keeps load within 0..20 pF
						if (wMerged[10:6] > `CSS_CAP_MAX)
							next_st.genCfg[10:6] = `CSS_CAP_MAX;
					end else if (st.awAddr == `CSS_ADDR_RELOAD) begin
						if (wMerged[0]) begin
							next_st.setWord = defaultSet;
							next_st.pllCfg = `CSS_DEF_PLLCFG;
							next_st.genCfg = `CSS_DEF_GENCFG;
						end
					end else if (rHit) begin
						next_st.setWord[st.awAddr[4:2]] = wMerged[5:0];
					end else begin
						next_st.bResp = 2'h2;
					end
					next_st.awHeld = 1'b0;
					next_st.wHeld = 1'b0;
					next_st.bValid = 1'b1;
					next_st.wrState = CSS_WR_RESP;
				end
			CSS_WR_RESP:
				if (s_axi_bready) begin
					next_st.bValid = 1'b0;
					next_st.wrState = CSS_WR_IDLE;
				end
			default: next_st.wrState = CSS_WR_IDLE;
		endcase

		// Read path: one read at a time, answer next cycle
		if (st.rValid) begin
			if (s_axi_rready)
				next_st.rValid = 1'b0;
		end else if (s_axi_arvalid) begin
			next_st.rValid = 1'b1;
			next_st.rResp = 2'h0;
			next_st.rData = 32'h0000_0000;
			case (s_axi_araddr)
				`CSS_ADDR_PLLCFG: next_st.rData = {27'h0, st.pllCfg};
				`CSS_ADDR_GENCFG: next_st.rData = {21'h0, st.genCfg};
				`CSS_ADDR_STATUS:
					next_st.rData = {20'h0, st.index, st.apply.outState1,
						st.apply.outState23, st.apply.spreadCode,
						st.apply.spreadDown, st.apply.freqSelB};
				`CSS_ADDR_RELOAD: next_st.rData = 32'h0000_0000;
				default:
					if (s_axi_araddr < `CSS_ADDR_PLLCFG
							&& s_axi_araddr[1:0] == 2'h0)
						next_st.rData = {26'h0,
							st.setWord[s_axi_araddr[4:2]]};
					else
						next_st.rResp = 2'h2;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Reset takes the factory image held in nonvolatile cells
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.setWord <= {{6{`CSS_DEF_SETX}}, `CSS_DEF_SET1,
				`CSS_DEF_SET0};
			st.pllCfg <= `CSS_DEF_PLLCFG;
			st.genCfg <= `CSS_DEF_GENCFG;
			st.wrState <= CSS_WR_IDLE;
			st.apply.outState23 <= CSS_OUT_HIZ;
			st.apply.outState1 <= CSS_OUT_HIZ;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = !st.awHeld;
	assign s_axi_wready = !st.wHeld;
	assign s_axi_bvalid = st.bValid;
	assign s_axi_bresp = st.bResp;
	assign s_axi_arready = !st.rValid;
	assign s_axi_rvalid = st.rValid;
	assign s_axi_rdata = st.rData;
	assign s_axi_rresp = st.rResp;
	assign applied = st.apply;
	assign settingIndex = st.index;
endmodule

`default_nettype wire

/* File: sim/css_host_pins.sv */
/*
 Host side of the select terminals.
 Assumes the bench sets want just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module css_host_pins (
	// Clock and request
	input  wire logic       clk_sys,
	input  wire logic [2:0] want,
	// Terminals
	output var  logic       selectPinZero,
	output var  logic       selectPinOne,
	output var  logic       selectPinTwo
);
	initial {selectPinTwo, selectPinOne, selectPinZero} = 3'h0;
	// Host drives all three terminals, bus mode or not
	always @(posedge clk_sys) begin
		{selectPinTwo, selectPinOne, selectPinZero} <= want;
	end
endmodule
`default_nettype wire

/* File: sim/css_selector_chk.sv */
/*
 Port checker of the setting selector.
 Assumes binding onto css_selector.
*/
`timescale 1ns/100ps
`default_nettype none
module css_selector_chk
	import css_pkg::*;
(
	// Clock, reset, pin
	input wire logic        clk_sys, arst_n, selectPinZero,
	// Bus
	input wire logic        s_axi_awvalid, s_axi_awready,
	input wire logic        s_axi_wvalid, s_axi_wready,
	input wire logic        s_axi_bvalid, s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid, s_axi_arready,
	input wire logic        s_axi_rvalid, s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Controls
	input wire css_apply_t  applied,
	input wire logic [2:0]  settingIndex
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic [2:0] up;
	// Past values are only trusted four edges after reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			up <= 3'h0;
		else if (up != 3'h4)
			up <= up + 3'h1;
	end
	// First reset edge only loads the flops; look one edge later
	rst_value_a: assert property (disable iff (1'b0)
		!arst_n ##1 !arst_n |->
		applied.outState1 == CSS_OUT_HIZ && settingIndex == 3'h0)
		else $error("reset value wrong");
	pdown_tie_a: assert property (applied.devicePowerDown ==
		(applied.outState1 == CSS_OUT_PDOWN
		&& applied.outState23 == CSS_OUT_PDOWN))
		else $error("power down not tied to states");
	cap_max_a: assert property (applied.loadCap <= 5'h14)
		else $error("load cap above limit");
	pin_sync_a: assert property (up == 3'h4 |->
		settingIndex[0] == $past(selectPinZero, 3))
		else $error("pin zero lag wrong");
	b_answer_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready
		|=> !s_axi_awready)
		else $error("address taken twice");
endmodule
bind css_selector css_selector_chk u_css_selector_chk (.clk_sys, .arst_n,
	.selectPinZero, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .applied, .settingIndex);
`default_nettype wire

/* File: sim/css_selector_tb_top.sv */
/*
 Self-checking bench of the setting selector.
 Assumes css_defines.svh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "css_defines.svh"
module css_selector_tb_top;
	import css_pkg::*;
	logic        clk_sys = 1'b0, arst_n = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [2:0]  settingIndex, want = 3'h0;
	logic        selectPinZero, selectPinOne, selectPinTwo;
	css_apply_t  applied;
	int          st[8];
	int          pll, gen, mismatches, num_checks, cyc, k, a, d;
	always #4 clk_sys = ~clk_sys;
	css_host_pins u_css_host_pins (.clk_sys, .want, .selectPinZero,
		.selectPinOne, .selectPinTwo);
	css_selector u_css_selector (.clk_sys, .arst_n, .selectPinZero,
		.selectPinOne, .selectPinTwo, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .applied,
		.settingIndex);
	////////////////////////////////////////////////////////////////////
	function automatic void dflt();
		foreach (st[i])
			st[i] = i == 0 ? `CSS_DEF_SET0 : `CSS_DEF_SETX;
		pll = `CSS_DEF_PLLCFG;
		gen = `CSS_DEF_GENCFG;
	endfunction
	// Bus mode masks terminals one and two
	function automatic int idx();
		return gen[4] ? int'(want) : int'(want[0]);
	endfunction
	function automatic css_apply_t expA();
		css_apply_t e;
		int s;
		s = st[idx()];
		e.freqSelB = s[0];
		e.spreadDown = pll[0];
		e.spreadCode = s[3:1];
		e.outState23 = css_out_t'(s[4] ? pll[4:3] : pll[2:1]);
		e.outState1 = css_out_t'(s[5] ? gen[3:2] : gen[1:0]);
		e.pllBypass = gen[5];
		e.devicePowerDown = e.outState23 == CSS_OUT_PDOWN
			&& e.outState1 == CSS_OUT_PDOWN;
		e.loadCap = gen[10:6];
		return e;
	endfunction
	function automatic int expR(int r);
		css_apply_t e;
		int x;
		e = expA();
		x = idx();
		case (r)
			32: return pll;
			36: return gen;
			40: return {20'h0, x[2:0], e.outState1, e.outState23,
				e.spreadCode, e.spreadDown, e.freqSelB};
			44: return 0;
			default: return st[r >> 2];
		endcase
	endfunction
	function automatic void mwr(int r, int v);
		if (r < 32)
			st[r >> 2] = v & 63;
		else if (r == 32)
			pll = v & 31;
		else if (r == 36) begin
			gen = v & 'h7FF;
			if (gen[10:6] > 20)
				gen[10:6] = 20;
		end else if (r == 44 && v[0])
			dflt();
	endfunction
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
		@(posedge clk_sys);
		s_axi_awaddr <= ad;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] ad);
		@(posedge clk_sys);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rdv = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic look();
		repeat (6) @(posedge clk_sys);
		chk(applied, expA());
		chk(settingIndex, idx());
		rd(12'h028);
		chk(rdv, expR(40));
	endtask
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// Cut short a hung handshake
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		dflt();
		void'($urandom(51));
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		look();
		want <= 3'h1;
		look();
		for (k = 0; k < 13; k++) begin
			rd(12'(k * 4));
			if (k < 12)
				chk(rdv, expR(k * 4));
			chk(resp, k == 12 ? 2'h2 : 2'h0);
		end
		repeat (60) begin
			k = $urandom % 11;
			a = k == 10 ? 'h100 : k * 4;
			d = $urandom;
			wr(12'(a), d);
			chk(resp, k == 10 ? 2'h2 : 2'h0);
			mwr(a, d);
			want <= 3'($urandom);
			look();
			rd(12'(a));
			if (k != 10)
				chk(rdv, expR(a));
		end
		wr(12'h02C, 32'h1);
		mwr(44, 1);
		look();
		end_of_test();
	end
endmodule
`default_nettype wire
